// ### core/req_fifo.sv
`timescale 1ns/100ps
// Small request buffer; read word sits in an output register
module req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Both sides
    req_fifo_if.store q
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
    logic [AW-1:0] wp_reg; // Write pointer
    logic [AW-1:0] rp_reg; // Read pointer
    logic [AW:0] cnt_reg; // Words in storage
    logic out_v_reg; // Output register holds a word
    logic [WIDTH-1:0] out_d_reg;

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    wire push = q.wr_valid && q.wr_ready;
    wire load_out = (cnt_reg != '0) && (!out_v_reg || q.rd_ready);
    assign q.wr_ready = (cnt_reg != (AW + 1)'(DEPTH)); // Honest full
    assign q.rd_valid = out_v_reg;
    assign q.rd_data = out_d_reg;

    // Storage write
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_reg] <= q.wr_data;
        end
    end

    // Pointers and count
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= push ? wp_reg + 1'b1 : wp_reg;
            rp_reg <= load_out ? rp_reg + 1'b1 : rp_reg;
            cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(load_out);
        end
    end

    // Output register; stalls while the drain side holds off
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            out_v_reg <= 1'b0;
            out_d_reg <= '0;
        end else if (load_out) begin
            out_v_reg <= 1'b1;
            out_d_reg <= mem[rp_reg];
        end else if (q.rd_ready) begin
            out_v_reg <= 1'b0;
        end
    end
endmodule

// ### core/req_fifo_if.sv
`timescale 1ns/100ps
// Carrier between the decoder and its request buffer
interface req_fifo_if #(parameter int WIDTH = 8);
    logic wr_valid; // Push side
    logic wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic rd_valid; // Pop side
    logic rd_ready;
    logic [WIDTH-1:0] rd_data;
    modport fill (output wr_valid, input wr_ready, output wr_data,
                  input rd_valid, output rd_ready, input rd_data);
    modport store (input wr_valid, output wr_ready, input wr_data,
                   output rd_valid, input rd_ready, output rd_data);
endinterface

// ### core/tap_pkg.sv
package tap_pkg;

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    localparam int IR_W = 4;
    localparam logic [3:0] IR_DRIVE_OUT = 4'h0; // Pads from preload
    localparam logic [3:0] IR_DRIVE_IN = 4'h1; // Core from preload
    localparam logic [3:0] IR_SAMPLE = 4'h2; // Sample/preload
    localparam logic [3:0] IR_ABORT = 4'h8;
    localparam logic [3:0] IR_DP_ACC = 4'ha; // Debug-port access
    localparam logic [3:0] IR_AP_ACC = 4'hb; // Access-port access
    localparam logic [3:0] IR_IDENT = 4'he;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1; // Fixed capture pattern

    // ------------------------------------------------------------
    // Data chains
    // ------------------------------------------------------------
    localparam int ID_W = 32;
    // Identification value: arbitrary, not a real maker code
    localparam logic [31:0] ID_VALUE = 32'h0abc_d001;
    localparam logic [31:0] ID_LSB_ONE = 32'h0000_0001;
    localparam int DBG_W = 35;
    localparam int NUM_PADS = 8;
    localparam int CELLS = 3; // Cells per pad
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;
    localparam int BSR_W = NUM_PADS * CELLS;

    // ------------------------------------------------------------
    // Debug request stream
    // ------------------------------------------------------------
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_DP = 2'h0;
    localparam logic [1:0] SEL_AP = 2'h1;
    localparam logic [1:0] SEL_ABT = 2'h2;
    localparam int REQ_W = SEL_W + DBG_W;
    localparam int FIFO_DEPTH = 4;

    // ------------------------------------------------------------
    // Controller states, Gray along the usual path
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SH_DR = 4'h6,
        ST_EX1_DR = 4'h7,
        ST_PA_DR = 4'h5,
        ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hc,
        ST_SEL_IR = 4'hd,
        ST_CAP_IR = 4'hf,
        ST_SH_IR = 4'he,
        ST_EX1_IR = 4'ha,
        ST_PA_IR = 4'hb,
        ST_EX2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } tap_state_type;

endpackage

// ### core/tap_scan_chain_decoder.sv
`timescale 1ns/100ps
module tap_scan_chain_decoder (
    // Clock and power-on reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Test port pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    output logic o_tdo,
    output logic o_tdo_oe,
    // External reset pin and pin configuration
    input wire logic i_ext_rst_n,
    input wire logic i_pins_to_gpio,
    output logic o_test_pins_en,
    // Pad side
    input wire logic [tap_pkg::NUM_PADS-1:0] i_pad_in,
    output logic [tap_pkg::NUM_PADS-1:0] o_pad_out,
    output logic [tap_pkg::NUM_PADS-1:0] o_pad_oe,
    // Core side
    input wire logic [tap_pkg::NUM_PADS-1:0] i_core_out,
    input wire logic [tap_pkg::NUM_PADS-1:0] i_core_oe,
    output logic [tap_pkg::NUM_PADS-1:0] o_core_in,
    // Debug access unit
    input wire logic [tap_pkg::DBG_W-1:0] i_dbg_rdata,
    output logic o_dbg_valid,
    input wire logic i_dbg_ready,
    output logic [tap_pkg::SEL_W-1:0] o_dbg_sel,
    output logic [tap_pkg::DBG_W-1:0] o_dbg_data
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_meta_reg; // First stage, read by second only
    logic [4:0] pin_sync_reg; // tck, tms, tdi, trst_n, ext_rst_n
    logic [tap_pkg::NUM_PADS-1:0] pad_meta_reg;
    logic [tap_pkg::NUM_PADS-1:0] pad_sync_reg;
    logic tck_dly_reg; // Previous synced clock, for edges

    // Two flops on every asynchronous input
    always_ff @(posedge i_clk) begin
        pin_meta_reg <= {i_tck, i_tms, i_tdi, i_trst_n, i_ext_rst_n};
        pin_sync_reg <= pin_meta_reg;
        pad_meta_reg <= i_pad_in;
        pad_sync_reg <= pad_meta_reg;
        tck_dly_reg <= pin_sync_reg[4];
    end

    wire tck_s = pin_sync_reg[4];
    wire tms_s = pin_sync_reg[3];
    wire tdi_s = pin_sync_reg[2];
    wire trst_s_n = pin_sync_reg[1];
    wire ext_rst_s_n = pin_sync_reg[0];
    // Edge pulses; tester clock must stay well below i_clk / 4
    wire tck_rise = tck_s && !tck_dly_reg;
    wire tck_fall = !tck_s && tck_dly_reg;

    // ------------------------------------------------------------
    // Controller state machine
    // ------------------------------------------------------------
    tap_pkg::tap_state_type state_reg;
    tap_pkg::tap_state_type state_next;

    // Standard sixteen-state walk on TMS
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            tap_pkg::ST_RESET: begin
                state_next = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
            end
            tap_pkg::ST_IDLE: begin
                state_next = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            end
            tap_pkg::ST_SEL_DR: begin
                state_next = tms_s ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
            end
            tap_pkg::ST_CAP_DR, tap_pkg::ST_SH_DR: begin
                state_next = tms_s ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
            end
            tap_pkg::ST_EX1_DR: begin
                state_next = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PA_DR;
            end
            tap_pkg::ST_PA_DR: begin
                state_next = tms_s ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PA_DR;
            end
            tap_pkg::ST_EX2_DR: begin
                state_next = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
            end
            tap_pkg::ST_UPD_DR, tap_pkg::ST_UPD_IR: begin
                state_next = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            end
            tap_pkg::ST_SEL_IR: begin
                state_next = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
            end
            tap_pkg::ST_CAP_IR, tap_pkg::ST_SH_IR: begin
                state_next = tms_s ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
            end
            tap_pkg::ST_EX1_IR: begin
                state_next = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PA_IR;
            end
            tap_pkg::ST_PA_IR: begin
                state_next = tms_s ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PA_IR;
            end
            tap_pkg::ST_EX2_IR: begin
                state_next = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
            end
        endcase
    end

    // Only power-on reset and TRST touch the controller
    // Power-on and TRST only
    wire tap_rst = i_srst || !trst_s_n;

    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            state_reg <= tap_pkg::ST_RESET;
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // Per-state strobes on the rising edge; at_reset and in_shift are plain state levels
    wire at_reset = (state_reg == tap_pkg::ST_RESET);
    wire cap_dr = tck_rise && (state_reg == tap_pkg::ST_CAP_DR);
    wire sh_dr = tck_rise && (state_reg == tap_pkg::ST_SH_DR);
    wire upd_dr = tck_rise && (state_reg == tap_pkg::ST_UPD_DR);
    wire cap_ir = tck_rise && (state_reg == tap_pkg::ST_CAP_IR);
    wire sh_ir = tck_rise && (state_reg == tap_pkg::ST_SH_IR);
    wire upd_ir = tck_rise && (state_reg == tap_pkg::ST_UPD_IR);
    wire in_shift = (state_reg == tap_pkg::ST_SH_DR) ||
                    (state_reg == tap_pkg::ST_SH_IR);

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    logic [tap_pkg::IR_W-1:0] ir_sh_reg; // Serial stage
    logic [tap_pkg::IR_W-1:0] ir_reg; // Active instruction

    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            ir_sh_reg <= tap_pkg::IR_CAPTURE;
        end else if (cap_ir) begin
            ir_sh_reg <= tap_pkg::IR_CAPTURE;
        end else if (sh_ir) begin
            ir_sh_reg <= {tdi_s, ir_sh_reg[tap_pkg::IR_W-1:1]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (tap_rst || at_reset) begin
            ir_reg <= tap_pkg::IR_IDENT;
        end else if (upd_ir) begin
            ir_reg <= ir_sh_reg;
        end
    end

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    // Boundary, debug-access, abort and identification codes
    wire is_out = (ir_reg == tap_pkg::IR_DRIVE_OUT);
    wire is_in = (ir_reg == tap_pkg::IR_DRIVE_IN);
    wire is_smp = (ir_reg == tap_pkg::IR_SAMPLE);
    wire is_abt = (ir_reg == tap_pkg::IR_ABORT);
    wire is_dp = (ir_reg == tap_pkg::IR_DP_ACC);
    wire is_ap = (ir_reg == tap_pkg::IR_AP_ACC);
    wire is_id = (ir_reg == tap_pkg::IR_IDENT);
    // Chain selects; all three boundary codes use one chain
    wire sel_bsr = is_out || is_in || is_smp;
    wire sel_dbg = is_dp || is_ap || is_abt;
    // Anything else, 1111 included, is bypass
    wire sel_byp = !(sel_bsr || sel_dbg || is_id);
    wire [tap_pkg::SEL_W-1:0] dbg_kind = is_dp ? tap_pkg::SEL_DP :
                                         is_ap ? tap_pkg::SEL_AP :
                                         tap_pkg::SEL_ABT;

    // ------------------------------------------------------------
    // Bypass and identification chains
    // ------------------------------------------------------------
    logic byp_reg;
    logic [tap_pkg::ID_W-1:0] id_reg;

    always_ff @(posedge i_clk) begin
        if (tap_rst || (cap_dr && sel_byp)) begin
            byp_reg <= 1'b0;
        end else if (sh_dr && sel_byp) begin
            byp_reg <= tdi_s;
        end
    end

    always_ff @(posedge i_clk) begin
        if (tap_rst || (cap_dr && is_id)) begin
            id_reg <= tap_pkg::ID_VALUE | tap_pkg::ID_LSB_ONE;
        end else if (sh_dr && is_id) begin
            id_reg <= {tdi_s, id_reg[tap_pkg::ID_W-1:1]};
        end
    end

    // ------------------------------------------------------------
    // Boundary chain
    // ------------------------------------------------------------
    logic [tap_pkg::BSR_W-1:0] bsr_reg; // Shift cells
    logic [tap_pkg::BSR_W-1:0] bsr_upd_reg; // Preload cells
    logic [tap_pkg::BSR_W-1:0] bsr_cap; // Sampled pad inputs, core outputs and enables
    logic [tap_pkg::NUM_PADS-1:0] pre_in; // Preloaded core inputs
    logic [tap_pkg::NUM_PADS-1:0] pre_out;
    logic [tap_pkg::NUM_PADS-1:0] pre_oe;

    // Pad 0, nearest the port, sits at the TDO end
    genvar gp;
    generate
        for (gp = 0; gp < tap_pkg::NUM_PADS; gp++) begin : g_pad
            localparam int B = gp * tap_pkg::CELLS;
            assign bsr_cap[B + tap_pkg::CELL_IN] = pad_sync_reg[gp];
            assign bsr_cap[B + tap_pkg::CELL_OUT] = i_core_out[gp];
            assign bsr_cap[B + tap_pkg::CELL_OE] = i_core_oe[gp];
            assign pre_in[gp] = bsr_upd_reg[B + tap_pkg::CELL_IN];
            assign pre_out[gp] = bsr_upd_reg[B + tap_pkg::CELL_OUT];
            assign pre_oe[gp] = bsr_upd_reg[B + tap_pkg::CELL_OE];
        end
    endgenerate

    // Capture on rising TCK in Capture-DR
    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            bsr_reg <= '0;
        end else if (cap_dr && sel_bsr) begin
            bsr_reg <= bsr_cap;
        end else if (sh_dr && sel_bsr) begin
            bsr_reg <= {tdi_s, bsr_reg[tap_pkg::BSR_W-1:1]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            bsr_upd_reg <= '0;
        end else if (upd_dr && sel_bsr) begin
            bsr_upd_reg <= bsr_reg;
        end
    end

    // Preload overrides pads or core inputs
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pad_out <= '0;
            o_pad_oe <= '0;
            o_core_in <= '0;
        end else begin
            o_pad_out <= is_out ? pre_out : i_core_out;
            o_pad_oe <= is_out ? pre_oe : i_core_oe;
            o_core_in <= is_in ? pre_in : pad_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Debug access chains (one shift register, three selects)
    // ------------------------------------------------------------
    logic [tap_pkg::DBG_W-1:0] dbg_reg;
    logic req_pend_reg; // Update waiting for buffer room
    logic [tap_pkg::REQ_W-1:0] req_reg;

    // 35-bit chain for the selected access
    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            dbg_reg <= '0;
        end else if (cap_dr && sel_dbg) begin
            dbg_reg <= i_dbg_rdata;
        end else if (sh_dr && sel_dbg) begin
            dbg_reg <= {tdi_s, dbg_reg[tap_pkg::DBG_W-1:1]};
        end
    end

    req_fifo_if #(.WIDTH(tap_pkg::REQ_W)) rq ();

    // Hold one update while the buffer is full; a newer one replaces it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            req_pend_reg <= 1'b0;
            req_reg <= '0;
        end else if (upd_dr && sel_dbg) begin
            req_pend_reg <= 1'b1;
            req_reg <= {dbg_kind, dbg_reg};
        end else if (rq.wr_ready) begin
            req_pend_reg <= 1'b0;
        end
    end

    assign rq.wr_valid = req_pend_reg;
    assign rq.wr_data = req_reg;
    assign rq.rd_ready = i_dbg_ready;
    assign o_dbg_valid = rq.rd_valid;
    assign o_dbg_sel = rq.rd_data[tap_pkg::REQ_W-1:tap_pkg::DBG_W];
    assign o_dbg_data = rq.rd_data[tap_pkg::DBG_W-1:0];

    req_fifo #(
        .WIDTH(tap_pkg::REQ_W),
        .DEPTH(tap_pkg::FIFO_DEPTH)
    ) u_req_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .q(rq.store)
    );

    // ------------------------------------------------------------
    // TDO
    // ------------------------------------------------------------
    wire dr_bit = sel_bsr ? bsr_reg[0] :
                  sel_dbg ? dbg_reg[0] :
                  is_id ? id_reg[0] : byp_reg;
    wire sel_bit = (state_reg == tap_pkg::ST_SH_IR) ? ir_sh_reg[0] : dr_bit;

    // Update on falling TCK, enable only while shifting
    always_ff @(posedge i_clk) begin
        if (tap_rst) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo <= in_shift ? sel_bit : 1'b0;
            o_tdo_oe <= in_shift;
        end
    end

    // ------------------------------------------------------------
    // Test pin configuration
    // ------------------------------------------------------------
    // Pin reset restores pins, leaves controller alone
    always_ff @(posedge i_clk) begin
        if (i_srst || !ext_rst_s_n) begin
            o_test_pins_en <= 1'b1;
        end else if (i_pins_to_gpio) begin
            o_test_pins_en <= 1'b0;
        end
    end

endmodule

// ### sim/jtag_tester.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Test port driver; clock stands low between scans
// ------------------------------------------------------------
module jtag_tester (
    // Tester pins
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n,
    input wire logic i_tdo
);
    localparam int HALF = 80; // Half of the 160 ns test clock
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_n = 1'b1;
    end
    // Mode set in low phase; TDO read late in high phase, clear of the sync lag
    task automatic step(input logic m, input logic d, output logic q);
        o_tms = m;
        o_tdi = d;
        #HALF;
        o_tck = 1'b1;
        #HALF;
        q = i_tdo;
        o_tck = 1'b0;
    endtask
    // Five ones reach reset, then idle
    task automatic to_idle();
        logic b;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
    // Idle to idle scan, new data shifted in as old shifts out
    task automatic scan(input logic ir, input logic [63:0] v, input int n, output logic [63:0] q);
        logic b;
        q = '0;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) step(i == n - 1, v[i], q[i]);
        step(1'b1, 1'b0, b);
        // Released data line shows the inverse of its last bit
        step(1'b0, ~v[n-1], b);
    endtask
    task automatic pulse_trst();
        o_trst_n = 1'b0;
        #400;
        o_trst_n = 1'b1;
    endtask
endmodule

// ### sim/tap_scan_chain_decoder_asserts.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module tap_asserts (
    // Clock and resets
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_trst_n,
    input wire logic i_ext_rst_n,
    // Test port
    input wire logic i_tck,
    input wire logic i_pins_to_gpio,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic o_test_pins_en,
    // Pads and stream
    input wire logic [tap_pkg::NUM_PADS-1:0] o_pad_out,
    input wire logic [tap_pkg::NUM_PADS-1:0] o_pad_oe,
    input wire logic i_dbg_ready,
    input wire logic o_dbg_valid,
    input wire logic [tap_pkg::SEL_W-1:0] o_dbg_sel,
    input wire logic [tap_pkg::DBG_W-1:0] o_dbg_data
);
    // One domain; reset checks override the disable
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_tdo_quiet_idle: assert property (!o_tdo_oe |-> !o_tdo)
        else $error("TDO high while not driving");
    // TDO moves only in low TCK
    a_tdo_after_fall: assert property (
        $changed(o_tdo) && i_trst_n && $past(i_trst_n, 5) |-> $past(!i_tck, 2))
        else $error("TDO changed outside a low test clock");
    a_por_port_idle: assert property (
        disable iff (1'b0) i_srst |=> !o_tdo_oe && !o_dbg_valid)
        else $error("Port active after power-on reset");
    a_por_pins_pads: assert property (
        disable iff (1'b0) i_srst |=> o_test_pins_en && o_pad_out == '0 && o_pad_oe == '0)
        else $error("Pins or pads wrong after power-on reset");
    a_req_held: assert property (
        o_dbg_valid && !i_dbg_ready |=> o_dbg_valid && $stable(o_dbg_data) && $stable(o_dbg_sel))
        else $error("Request changed before it was taken");
    a_sel_known: assert property (o_dbg_valid |-> o_dbg_sel <= tap_pkg::SEL_ABT)
        else $error("Unknown request select");
    a_pin_cfg_back: assert property ($fell(i_ext_rst_n) |-> ##[1:4] o_test_pins_en)
        else $error("Pin reset did not restore test pins");
    a_pin_cfg_gpio: assert property (
        i_ext_rst_n [*4] ##0 i_pins_to_gpio |=> !o_test_pins_en)
        else $error("Pins stayed in test function");
    a_trst_quiet: assert property (!i_trst_n [*5] |-> !o_tdo_oe && !o_tdo)
        else $error("TDO active during test reset");
endmodule

bind tap_scan_chain_decoder tap_asserts i_tap_asserts (.i_clk, .i_srst, .i_trst_n,
    .i_ext_rst_n, .i_tck, .i_pins_to_gpio, .o_tdo, .o_tdo_oe, .o_test_pins_en,
    .o_pad_out, .o_pad_oe, .i_dbg_ready, .o_dbg_valid, .o_dbg_sel, .o_dbg_data);

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
    localparam int NP = tap_pkg::NUM_PADS;
    logic clk, srst, tck, tms, tdi, trst_n, tdo, tdo_oe, ext_rst_n, to_gpio, pins_en;
    logic dbg_valid, dbg_ready, stall;
    logic [NP-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
    logic [tap_pkg::SEL_W-1:0] sel;
    logic [tap_pkg::DBG_W-1:0] rdata, ddata;
    logic [tap_pkg::BSR_W-1:0] pre; // Preload model
    logic [3:0] cur; // Active instruction model
    logic [tap_pkg::REQ_W-1:0] exq[$]; // Expected requests
    int fails = 0;
    int num_checks = 0;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    tap_scan_chain_decoder i_tap_scan_chain_decoder (.i_clk(clk), .i_srst(srst), .i_tck(tck),
        .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
        .i_ext_rst_n(ext_rst_n), .i_pins_to_gpio(to_gpio), .o_test_pins_en(pins_en),
        .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe), .i_core_out(core_out),
        .i_core_oe(core_oe), .o_core_in(core_in), .i_dbg_rdata(rdata), .o_dbg_valid(dbg_valid),
        .i_dbg_ready(dbg_ready), .o_dbg_sel(sel), .o_dbg_data(ddata));
    jtag_tester i_jtag_tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
        .i_tdo(tdo));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Chain length per code; unlisted codes give one bit
    function automatic int chain_len(input logic [3:0] c);
        case (c)
            4'h0, 4'h1, 4'h2: return tap_pkg::BSR_W;
            4'h8, 4'ha, 4'hb: return tap_pkg::DBG_W;
            4'he: return tap_pkg::ID_W;
            default: return 1;
        endcase
    endfunction
    // Load an instruction, capture pattern shifts out
    task automatic ir_load(input logic [3:0] c);
        logic [63:0] q;
        i_jtag_tester.scan(1'b1, 64'(c), 4, q);
        chk(q, 64'(tap_pkg::IR_CAPTURE));
        cur = c;
    endtask
    // Data scan of 64 bits through the active chain, then pad checks
    task automatic dr();
        logic [63:0] v, q, e, m;
        logic [NP-1:0] eo, ee, ei;
        int n;
        v = {$urandom, $urandom};
        n = chain_len(cur);
        e = '0;
        for (int k = 0; k < NP; k++) begin
            e[3*k+tap_pkg::CELL_IN] = pad_in[k];
            e[3*k+tap_pkg::CELL_OUT] = core_out[k];
            e[3*k+tap_pkg::CELL_OE] = core_oe[k];
        end
        if (cur == 4'h8 || cur == 4'ha || cur == 4'hb) begin
            e = 64'(rdata);
            exq.push_back({(cur == 4'h8) ? tap_pkg::SEL_ABT :
                (cur == 4'ha) ? tap_pkg::SEL_DP : tap_pkg::SEL_AP, v[63 -: tap_pkg::DBG_W]});
        end
        if (cur == tap_pkg::IR_IDENT) e = 64'(tap_pkg::ID_VALUE);
        if (cur > 4'h2 && n == 1) e = '0;
        e = e | (v << n);
        // Capture under drive codes is masked off here, so only shift-through counts
        m = (cur <= 4'h1) ? ~64'h0 << n : ~64'h0;
        i_jtag_tester.scan(1'b0, v, 64, q);
        chk(q & m, e & m);
        if (cur <= 4'h2) pre = v[63 -: tap_pkg::BSR_W];
        for (int k = 0; k < NP; k++) begin
            eo[k] = (cur == 4'h0) ? pre[3*k+tap_pkg::CELL_OUT] : core_out[k];
            ee[k] = (cur == 4'h0) ? pre[3*k+tap_pkg::CELL_OE] : core_oe[k];
            ei[k] = (cur == 4'h1) ? pre[3*k+tap_pkg::CELL_IN] : pad_in[k];
        end
        repeat (10) @(negedge clk);
        chk(64'({pad_out, pad_oe, core_in, tdo_oe}), 64'({eo, ee, ei, 1'b0}));
    endtask

    // Far side takes requests at random, or stalls
    always @(negedge clk) dbg_ready <= stall ? 1'b0 : 1'(($urandom % 4) != 0);
    always @(posedge clk) begin
        if (dbg_valid === 1'b1 && dbg_ready === 1'b1)
            chk(64'({sel, ddata}), 64'(exq.size() > 0 ? exq.pop_front() : 'x));
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [63:0] r;
        srst = 1'b1;
        ext_rst_n = 1'b1;
        to_gpio = 1'b0;
        stall = 1'b0;
        dbg_ready = 1'b0;
        {pad_in, core_out, core_oe, rdata} = '0;
        pre = '0;
        void'($urandom(60));
        repeat (3) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        i_jtag_tester.to_idle();
        cur = tap_pkg::IR_IDENT;
        dr();
        $display("Test reset_ident done");
        // Every code, twice, with fresh pad and read values
        repeat (2) for (int c = 0; c < 16; c++) begin
            @(negedge clk);
            r = {$urandom, $urandom};
            pad_in = r[0 +: NP];
            core_out = r[NP +: NP];
            core_oe = r[2*NP +: NP];
            rdata = {r[63:61], $urandom};
            ir_load(4'(c));
            dr();
        end
        $display("Test all_codes done");
        ir_load(tap_pkg::IR_DP_ACC);
        stall = 1'b1;
        repeat (5) dr();
        chk(64'(dbg_valid), 64'h1);
        stall = 1'b0;
        repeat (60) @(negedge clk);
        chk(64'(exq.size()), 64'h0);
        $display("Test stream_fill done");
        ir_load(tap_pkg::IR_BYPASS);
        i_jtag_tester.pulse_trst();
        i_jtag_tester.to_idle();
        cur = tap_pkg::IR_IDENT;
        pre = '0;
        dr();
        $display("Test test_reset done");
        ir_load(tap_pkg::IR_BYPASS);
        @(negedge clk) to_gpio = 1'b1;
        @(negedge clk) to_gpio = 1'b0;
        repeat (3) @(negedge clk);
        chk(64'(pins_en), 64'h0);
        ext_rst_n = 1'b0;
        repeat (4) @(negedge clk);
        ext_rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk(64'(pins_en), 64'h1);
        dr();
        $display("Test pin_reset done");
        @(negedge clk) srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        i_jtag_tester.to_idle();
        cur = tap_pkg::IR_IDENT;
        pre = '0;
        dr();
        $display("Test power_reset done");
        tally_and_finish();
    end
    // Watchdog: the run needs about 0.52 ms
    initial begin
        #1_200_000;
        fails++;
        $display("Error at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
        tally_and_finish();
    end
endmodule
